// ==== design/iaet_pkg.sv ====
// Purpose: shared constants and types for the interrupt and event transfer block
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: node and channel counts are fixed, not parameters
package iaet_pkg;
   localparam int NODES = 96;
   localparam int NODE_W = 7;
   localparam int CHANS = 8;
   localparam int CH_W = 3;
   localparam int PRIO_W = 4;
   localparam int ADDR_W = 24;
   localparam int CNT_W = 8;
   localparam int EDGE_N = 4;
   localparam int SEL_BASE = 88;
   localparam int SEL_N = 4;
   localparam int SH_N = 8;
   localparam int SEL_W = 3;
   localparam int RRU_BASE = 92;
   localparam int TRAP_W = 3;
   localparam int LAT_W = 4;
   localparam int LAT_HIT = 7;
   localparam int LAT_MISS = 11;
   localparam logic [LAT_W-1:0] LAT_HIT_CNT = LAT_W'(LAT_HIT - 1);
   localparam logic [LAT_W-1:0] LAT_MISS_CNT = LAT_W'(LAT_MISS - 1);
   localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
   localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
   localparam logic [ADDR_W-1:0] PTR_RST = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [1:0] GATE_OFF = 2'h0;
   localparam logic [1:0] GATE_ALL = 2'h1;
   localparam logic [1:0] GATE_MATCH = 2'h2;
   localparam logic [1:0] GATE_MISS = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RESP} iaet_state_e;
endpackage : iaet_pkg

// ==== design/iaet_rru.sv ====
// Purpose: request routing unit: edge trigger logic, routing matrix, output gating
// Assumes: ext_in comes from pins, asynchronous to clk
// Notes: outputs are one-cycle request pulses
`timescale 1ns/10ps
module iaet_rru (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [iaet_pkg::EDGE_N-1:0] ext_in,
   input wire logic [iaet_pkg::EDGE_N-1:0] edge_rise,
   input wire logic [iaet_pkg::EDGE_N-1:0] edge_fall,
   input wire logic [iaet_pkg::EDGE_N*iaet_pkg::EDGE_N-1:0] route,
   input wire logic [iaet_pkg::EDGE_N*iaet_pkg::EDGE_N-1:0] pat_sel,
   input wire logic [2*iaet_pkg::EDGE_N-1:0] gate_mode,
   output logic [iaet_pkg::EDGE_N-1:0] rru_req
);
   import iaet_pkg::*;
   logic [EDGE_N-1:0] s1_reg, s2_reg, s3_reg, req_reg, req_next, ev;

   // s1 feeds only s2; edges are taken between s2 and s3
   always_comb begin
      ev = (s2_reg & ~s3_reg & edge_rise) | (~s2_reg & s3_reg & edge_fall);
      for (int j = 0; j < EDGE_N; j++) begin
         logic hit, match, pass;
         hit = |(ev & route[j*EDGE_N +: EDGE_N]);
         match = &(s2_reg | ~pat_sel[j*EDGE_N +: EDGE_N]);
         unique case (gate_mode[2*j +: 2])
            GATE_OFF: pass = 1'b0;
            GATE_ALL: pass = 1'b1;
            GATE_MATCH: pass = match;
            GATE_MISS: pass = ~match;
         endcase
         req_next[j] = hit & pass;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         req_reg <= '0;
      end else begin
         s1_reg <= ext_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         req_reg <= req_next;
      end
   end
   assign rru_req = req_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   rise_detect_a: assert property (s2_reg[0] && !s3_reg[0] && edge_rise[0] && route[0] && gate_mode[1:0] == GATE_ALL
      |=> rru_req[0]) else $error("rising edge not passed");
   fall_ignore_a: assert property (!s2_reg[0] && s3_reg[0] && !edge_fall[0] && route[3:0] == 4'h1
      |=> !rru_req[0]) else $error("unselected falling edge passed");
   gate_miss_a: assert property (gate_mode[1:0] == GATE_MISS && (&(s2_reg | ~pat_sel[3:0]))
      |=> !rru_req[0]) else $error("request passed on pattern match in miss mode");
endmodule : iaet_rru

// ==== design/iaet_top.sv ====
// Purpose: interrupt nodes, priority arbitration, event transfer channels and trap entry
// Assumes: node sources, trap requests and CPU status share clk; config is held steady by software
// Notes: the memory bus performs the whole move in the single stolen cycle
`timescale 1ns/10ps
module iaet_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [iaet_pkg::SEL_BASE-1:0] src_req,
   input wire logic [iaet_pkg::SH_N-1:0] sh_src,
   input wire logic [iaet_pkg::SEL_N*iaet_pkg::SEL_W-1:0] source_select_regs,
   input wire logic [iaet_pkg::EDGE_N-1:0] ext_in,
   input wire logic [iaet_pkg::EDGE_N-1:0] edge_rise,
   input wire logic [iaet_pkg::EDGE_N-1:0] edge_fall,
   input wire logic [iaet_pkg::EDGE_N*iaet_pkg::EDGE_N-1:0] route,
   input wire logic [iaet_pkg::EDGE_N*iaet_pkg::EDGE_N-1:0] pat_sel,
   input wire logic [2*iaet_pkg::EDGE_N-1:0] gate_mode,
   input wire logic [iaet_pkg::NODES-1:0] node_en,
   input wire logic [iaet_pkg::NODES*iaet_pkg::PRIO_W-1:0] node_prio,
   input wire logic [iaet_pkg::NODES-1:0] node_xfer,
   input wire logic [iaet_pkg::NODES*iaet_pkg::CH_W-1:0] node_ch,
   input wire logic [iaet_pkg::PRIO_W-1:0] cpu_prio,
   input wire logic jc_hit,
   input wire logic trap_req,
   input wire logic [iaet_pkg::TRAP_W-1:0] trap_id,
   input wire logic ch_load,
   input wire logic [iaet_pkg::CH_W-1:0] ch_sel,
   input wire logic [iaet_pkg::ADDR_W-1:0] ch_src_in,
   input wire logic [iaet_pkg::ADDR_W-1:0] ch_dst_in,
   input wire logic [iaet_pkg::CNT_W-1:0] ch_cnt_in,
   input wire logic [iaet_pkg::CHANS-1:0] ch_cont,
   input wire logic [iaet_pkg::CHANS-1:0] ch_inc_src,
   input wire logic [iaet_pkg::CHANS-1:0] ch_inc_dst,
   input wire logic [iaet_pkg::CHANS-1:0] ch_word,
   output logic [iaet_pkg::NODES-1:0] node_flag,
   output logic [iaet_pkg::CHANS-1:0] ch_zero,
   output logic cpu_suspend,
   output logic cpu_steal,
   output logic irq_branch,
   output logic irq_trap,
   output logic [iaet_pkg::NODE_W-1:0] irq_vec,
   output logic mem_move,
   output logic mem_word,
   output logic [iaet_pkg::ADDR_W-1:0] mem_src,
   output logic [iaet_pkg::ADDR_W-1:0] mem_dst
);
   import iaet_pkg::*;

   // lowest index wins a tie; floor is the CPU priority, so equal priority never preempts
   function automatic logic [NODE_W:0] iaet_pick(input logic [NODES-1:0] act,
         input logic [NODES*PRIO_W-1:0] pr, input logic [PRIO_W-1:0] floor);
      logic [PRIO_W-1:0] best;
      logic [NODE_W:0] res;
      best = floor;
      res = '0;
      for (int i = 0; i < NODES; i++) begin
         if (act[i] && pr[i*PRIO_W +: PRIO_W] > best) begin
            best = pr[i*PRIO_W +: PRIO_W];
            res = {1'b1, NODE_W'(i)};
         end
      end
      return res;
   endfunction : iaet_pick

   iaet_state_e state_reg, state_next;
   logic [NODES-1:0] flag_reg, flag_next, set_vec, clr;
   logic [LAT_W-1:0] lat_reg, lat_next;
   logic [NODE_W-1:0] vec_reg, vec_next;
   logic trap_reg, trap_next, trap_pend_reg, trap_pend_next;
   logic branch_reg, branch_next, move_reg, move_next;
   logic word_reg, word_next;
   logic [ADDR_W-1:0] msrc_reg, msrc_next, mdst_reg, mdst_next;
   logic [ADDR_W-1:0] src_reg [CHANS];
   logic [ADDR_W-1:0] src_next [CHANS];
   logic [ADDR_W-1:0] dst_reg [CHANS];
   logic [ADDR_W-1:0] dst_next [CHANS];
   logic [CNT_W-1:0] cnt_reg [CHANS];
   logic [CNT_W-1:0] cnt_next [CHANS];
   logic [EDGE_N-1:0] rru_req;
   logic [NODE_W:0] pick;
   logic found, wxfer, can_xfer, accept;
   logic [NODE_W-1:0] widx;
   logic [CH_W-1:0] wch;
   logic [CNT_W-1:0] cnt_win;
   logic [ADDR_W-1:0] src_win, step_win;
   logic [PRIO_W-1:0] wprio;

   iaet_rru u_rru (
      .clk(clk),
      .rstn(rstn),
      .ext_in(ext_in),
      .edge_rise(edge_rise),
      .edge_fall(edge_fall),
      .route(route),
      .pat_sel(pat_sel),
      .gate_mode(gate_mode),
      .rru_req(rru_req)
   );

   // node source map: dedicated, selected from the shared pool, routing unit
   assign set_vec[SEL_BASE-1:0] = src_req;
   generate
      for (genvar g = 0; g < SEL_N; g++) begin : g_sel
         assign set_vec[SEL_BASE+g] = sh_src[source_select_regs[g*SEL_W +: SEL_W]];
      end
      for (genvar g = 0; g < EDGE_N; g++) begin : g_rru
         assign set_vec[RRU_BASE+g] = rru_req[g];
      end
      for (genvar c = 0; c < CHANS; c++) begin : g_zero
         assign ch_zero[c] = (cnt_reg[c] == CNT_RST);
      end
   endgenerate

   assign pick = iaet_pick(flag_reg & node_en, node_prio, cpu_prio);
   assign found = pick[NODE_W];
   assign widx = pick[NODE_W-1:0];
   assign wch = node_ch[int'(widx)*CH_W +: CH_W];
   assign wprio = node_prio[int'(widx)*PRIO_W +: PRIO_W];
   assign wxfer = node_xfer[widx];
   assign cnt_win = cnt_reg[wch];
   assign src_win = src_reg[wch];
   assign step_win = ch_word[wch] ? STEP_WORD : STEP_BYTE;
   // an exhausted channel falls back to the standard interrupt of its source
   assign can_xfer = wxfer && (ch_cont[wch] || cnt_win != CNT_RST);
   assign accept = (state_reg == ST_IDLE) && !trap_pend_reg && found;

   always_comb begin
      state_next = state_reg;
      lat_next = lat_reg;
      vec_next = vec_reg;
      trap_next = trap_reg;
      trap_pend_next = trap_pend_reg | trap_req;
      branch_next = 1'b0;
      move_next = 1'b0;
      clr = '0;
      unique case (state_reg)
         ST_IDLE: begin
            if (trap_pend_reg) begin
               trap_pend_next = trap_req;
               trap_next = 1'b1;
               vec_next = {{(NODE_W-TRAP_W){1'b0}}, trap_id};
               lat_next = jc_hit ? LAT_HIT_CNT : LAT_MISS_CNT;
               state_next = ST_RESP;
            end else if (found) begin
               clr[widx] = 1'b1;
               trap_next = 1'b0;
               vec_next = widx;
               if (can_xfer) begin
                  move_next = 1'b1;
                  state_next = ST_XFER;
               end else begin
                  lat_next = jc_hit ? LAT_HIT_CNT : LAT_MISS_CNT;
                  state_next = ST_RESP;
               end
            end
         end
         ST_XFER: state_next = ST_IDLE;
         ST_RESP: begin
            if (lat_reg == '0) begin
               branch_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               lat_next = lat_reg - 1'b1;
            end
         end
      endcase
      // a new event in the clearing cycle keeps the flag set
      flag_next = (flag_reg & ~clr) | set_vec;
   end

   always_comb begin
      msrc_next = msrc_reg;
      mdst_next = mdst_reg;
      word_next = word_reg;
      src_next = src_reg;
      dst_next = dst_reg;
      cnt_next = cnt_reg;
      if (accept && can_xfer) begin
         msrc_next = src_reg[wch];
         mdst_next = dst_reg[wch];
         word_next = ch_word[wch];
         if (ch_inc_src[wch]) src_next[wch] = src_reg[wch] + step_win;
         if (ch_inc_dst[wch]) dst_next[wch] = dst_reg[wch] + step_win;
         if (!ch_cont[wch]) cnt_next[wch] = cnt_reg[wch] - 1'b1;
      end
      // a software reload wins over a transfer on the same channel
      if (ch_load) begin
         src_next[ch_sel] = ch_src_in;
         dst_next[ch_sel] = ch_dst_in;
         cnt_next[ch_sel] = ch_cnt_in;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         flag_reg <= '0;
         lat_reg <= '0;
         vec_reg <= '0;
         trap_reg <= 1'b0;
         trap_pend_reg <= 1'b0;
         branch_reg <= 1'b0;
         move_reg <= 1'b0;
         word_reg <= 1'b0;
         msrc_reg <= PTR_RST;
         mdst_reg <= PTR_RST;
         for (int c = 0; c < CHANS; c++) begin
            src_reg[c] <= PTR_RST;
            dst_reg[c] <= PTR_RST;
            cnt_reg[c] <= CNT_RST;
         end
      end else begin
         state_reg <= state_next;
         flag_reg <= flag_next;
         lat_reg <= lat_next;
         vec_reg <= vec_next;
         trap_reg <= trap_next;
         trap_pend_reg <= trap_pend_next;
         branch_reg <= branch_next;
         move_reg <= move_next;
         word_reg <= word_next;
         msrc_reg <= msrc_next;
         mdst_reg <= mdst_next;
         src_reg <= src_next;
         dst_reg <= dst_next;
         cnt_reg <= cnt_next;
      end
   end

   assign node_flag = flag_reg;
   assign cpu_suspend = (state_reg == ST_RESP);
   assign cpu_steal = (state_reg == ST_XFER);
   assign irq_branch = branch_reg;
   assign irq_trap = trap_reg;
   assign irq_vec = vec_reg;
   assign mem_move = move_reg;
   assign mem_word = word_reg;
   assign mem_src = msrc_reg;
   assign mem_dst = mdst_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_int_hit;
      accept && !can_xfer && jc_hit;
   endsequence
   sequence s_int_miss;
      accept && !can_xfer && !jc_hit;
   endsequence
   sequence s_xfer;
      accept && can_xfer;
   endsequence
   lat_hit_a: assert property (s_int_hit |-> ##1 (!irq_branch)[*7] ##1 irq_branch)
      else $error("hit latency not 7");
   lat_miss_a: assert property (s_int_miss |-> ##1 (!irq_branch)[*8] ##1 (!irq_branch)[*3] ##1 irq_branch)
      else $error("miss latency not 11");
   steal_one_a: assert property (s_xfer |=> cpu_steal && mem_move && !cpu_suspend ##1 !cpu_steal && !irq_branch)
      else $error("transfer did not steal one cycle");
   flag_clear_a: assert property (accept && !set_vec[widx] |=> !node_flag[$past(widx)])
      else $error("request flag not cleared");
   cnt_dec_a: assert property (s_xfer ##0 (!ch_cont[wch] && !ch_load)
      |=> cnt_reg[$past(wch)] == $past(cnt_win) - 8'h01) else $error("counter not decremented");
   cnt_hold_a: assert property (s_xfer ##0 (ch_cont[wch] && !ch_load)
      |=> cnt_reg[$past(wch)] == $past(cnt_win)) else $error("continuous mode counted");
   src_inc_a: assert property (s_xfer ##0 (ch_inc_src[wch] && !ch_load)
      |=> mem_src == $past(src_win) && src_reg[$past(wch)] == $past(src_win) + $past(step_win))
      else $error("source pointer step wrong");
   zero_int_a: assert property (accept && wxfer && !ch_cont[wch] && cnt_win == CNT_RST
      |=> cpu_suspend && !mem_move && irq_vec == $past(widx)) else $error("exhausted channel did not interrupt");
   prio_win_a: assert property (accept |-> wprio > cpu_prio)
      else $error("node below CPU priority served");
   trap_first_a: assert property (state_reg == ST_IDLE && trap_pend_reg |=> cpu_suspend && irq_trap && !mem_move)
      else $error("trap not taken first");
endmodule : iaet_top

// ==== verif/iaet_cpu_model.sv ====
// Purpose: far side model: request sources, trap source and cpu counters
// Assumes: pulses launched at the falling edge, one cycle wide
// Notes: only counts services; judging is left to the bench
`timescale 1ns/10ps
module iaet_cpu_model (
   input wire logic clk,
   input wire logic irq_branch,
   input wire logic mem_move,
   output logic [iaet_pkg::SEL_BASE-1:0] src_req,
   output logic [iaet_pkg::SH_N-1:0] sh_src,
   output logic trap_req,
   output int branch_cnt,
   output int move_cnt
);
   import iaet_pkg::*;
   initial begin
      src_req = '0;
      sh_src = '0;
      trap_req = 1'b0;
      branch_cnt = 0;
      move_cnt = 0;
   end
   // one-cycle pulses so that each call is exactly one source event
   task pulse(input logic [95:0] m, input logic t);
      @(negedge clk);
      src_req = m[87:0];
      sh_src = m[95:88];
      trap_req = t;
      @(negedge clk);
      src_req = '0;
      sh_src = '0;
      trap_req = 1'b0;
   endtask : pulse
   always @(posedge clk) begin
      if (irq_branch === 1'b1) branch_cnt <= branch_cnt + 1;
      if (mem_move === 1'b1) move_cnt <= move_cnt + 1;
   end
endmodule : iaet_cpu_model

// ==== verif/test_interrupt_and_event_transfer.sv ====
// Purpose: self-checking bench for the interrupt and event transfer block
// Assumes: inputs change at the falling edge; the clock runs at 10 MHz
// Notes: model keeps channel pointers and counters in ints, branch vectors in a queue
`timescale 1ns/10ps
module test_interrupt_and_event_transfer;
   import iaet_pkg::*;
   logic clk, rstn, jc_hit, trap_req, ch_load;
   logic [SEL_BASE-1:0] src_req;
   logic [SH_N-1:0] sh_src;
   logic [SEL_N*SEL_W-1:0] source_select_regs;
   logic [EDGE_N-1:0] ext_in, edge_rise, edge_fall;
   logic [15:0] route, pat_sel;
   logic [7:0] gate_mode;
   logic [NODES-1:0] node_en, node_xfer, node_flag;
   logic [NODES*PRIO_W-1:0] node_prio;
   logic [NODES*CH_W-1:0] node_ch;
   logic [PRIO_W-1:0] cpu_prio;
   logic [TRAP_W-1:0] trap_id;
   logic [CH_W-1:0] ch_sel;
   logic [ADDR_W-1:0] ch_src_in, ch_dst_in, mem_src, mem_dst;
   logic [CNT_W-1:0] ch_cnt_in;
   logic [CHANS-1:0] ch_cont, ch_inc_src, ch_inc_dst, ch_word, ch_zero;
   logic cpu_suspend, cpu_steal, irq_branch, irq_trap, mem_move, mem_word;
   logic [NODE_W-1:0] irq_vec;
   logic [52:0] s;
   logic [3:0] sf;
   int errors, checks_done, seed, bcnt, mcnt, nb, nm, n, ns;
   int sm[8], dm[8], cm[8];
   int vq[$];
   iaet_top u_iaet_top (.clk, .rstn, .src_req, .sh_src, .source_select_regs, .ext_in, .edge_rise,
      .edge_fall, .route, .pat_sel, .gate_mode, .node_en, .node_prio, .node_xfer, .node_ch, .cpu_prio,
      .jc_hit, .trap_req, .trap_id, .ch_load, .ch_sel, .ch_src_in, .ch_dst_in, .ch_cnt_in, .ch_cont,
      .ch_inc_src, .ch_inc_dst, .ch_word, .node_flag, .ch_zero, .cpu_suspend, .cpu_steal, .irq_branch,
      .irq_trap, .irq_vec, .mem_move, .mem_word, .mem_src, .mem_dst);
   iaet_cpu_model u_iaet_cpu_model (.clk, .irq_branch, .mem_move, .src_req, .sh_src, .trap_req,
      .branch_cnt(bcnt), .move_cnt(mcnt));
   task conclude;
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task chk(input logic [95:0] g, input logic [95:0] e);
      checks_done++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         errors++;
      end
   endtask : chk
   // counts falling edges from the cycle after the source pulse; bounded wait
   task serve(output int k, output logic [52:0] snap);
      k = 1;
      ns = 0;
      while (irq_branch !== 1'b1 && mem_move !== 1'b1) begin
         if (k > 40) begin
            errors++;
            conclude();
         end
         @(negedge clk);
         k++;
         if (cpu_suspend === 1'b1) ns++;
      end
      snap = {mem_move, cpu_steal, cpu_suspend, irq_branch, mem_word, mem_src, mem_dst};
      if (irq_branch === 1'b1) begin
         nb++;
         chk({irq_trap, irq_vec}, vq.pop_front());
      end else nm++;
      @(negedge clk);
   endtask : serve
   // one shared source event: every node whose selector names it latches a request
   task shp(input int i);
      u_iaet_cpu_model.pulse(96'h1 << (88 + i), 1'b0);
      for (int j = 0; j < 4; j++) begin
         if (int'(source_select_regs[j*3 +: 3]) == i) sf[j] = 1'b1;
      end
      chk(node_flag[91:88], sf);
   endtask : shp
   task cfg(input int nd, input int p, input logic x, input int c);
      node_en[nd] = 1'b1;
      node_prio[nd*4 +: 4] = 4'(p);
      node_xfer[nd] = x;
      node_ch[nd*3 +: 3] = 3'(c);
   endtask : cfg
   task load(input int c, input int a, input int b, input int k);
      ch_load = 1'b1;
      ch_sel = 3'(c);
      ch_src_in = 24'(a);
      ch_dst_in = 24'(b);
      ch_cnt_in = 8'(k);
      sm[c] = ch_src_in;
      dm[c] = ch_dst_in;
      cm[c] = k;
      @(negedge clk);
      ch_load = 1'b0;
   endtask : load
   task xfer(input int nd, input int c);
      int st;
      logic irq;
      st = ch_word[c] ? 2 : 1;
      irq = (cm[c] == 0 && !ch_cont[c]);
      if (irq) vq.push_back(nd);
      u_iaet_cpu_model.pulse(96'h1 << nd, 1'b0);
      serve(n, s);
      if (irq) begin
         chk(n, jc_hit ? LAT_HIT + 2 : LAT_MISS + 2);
         chk(ns, jc_hit ? LAT_HIT : LAT_MISS);
         chk(s[52:51], 2'b00);
      end else begin
         chk(n, 2);
         chk(s[52:48], {4'b1100, ch_word[c]});
         chk(s[47:0], {sm[c][23:0], dm[c][23:0]});
         if (ch_inc_src[c]) sm[c] += st;
         if (ch_inc_dst[c]) dm[c] += st;
         if (!ch_cont[c]) cm[c]--;
      end
      chk(ch_zero[c], cm[c] == 0);
      chk(node_flag[nd], 0);
   endtask : xfer
   // a level change on the pins, then the expected routed services in node order
   task edges(input logic [3:0] v, input logic [3:0] m);
      ext_in = v;
      for (int j = 0; j < 4; j++) begin
         if (m[j]) begin
            vq.push_back(92 + j);
            serve(n, s);
         end
      end
      repeat (12) @(negedge clk);
      chk(node_flag[95:92], 0);
   endtask : edges
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {errors, checks_done, nb, nm, jc_hit, ch_load} = '0;
      {source_select_regs, ext_in, edge_rise, edge_fall, route, pat_sel, gate_mode} = '0;
      {node_en, node_xfer, node_prio, node_ch, cpu_prio, trap_id, ch_sel} = '0;
      {ch_src_in, ch_dst_in, ch_cnt_in, ch_inc_src, ch_inc_dst, ch_word} = '0;
      ch_cont = 8'h80;
      seed = 30993;
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      chk(node_flag, 0);
      chk({ch_zero, cpu_suspend, cpu_steal, irq_branch, mem_move, irq_vec}, {8'hFF, 11'h0});
      // channel 7 runs continuous, so its counter must never move
      for (int c = 0; c < 8; c++) begin
         cfg(c * 11 + 3, c + 1, 1'b1, c);
         {ch_word[c], ch_inc_src[c], ch_inc_dst[c]} = 3'($random(seed));
         load(c, $random(seed), $random(seed), c % 3);
         repeat (4) begin
            jc_hit = 1'($random(seed));
            xfer(c * 11 + 3, c);
         end
      end
      cpu_prio = 4'h5;
      cfg(20, 5, 1'b0, 0);
      cfg(30, 7, 1'b0, 0);
      cfg(40, 9, 1'b0, 0);
      cfg(60, 9, 1'b0, 0);
      cfg(50, 15, 1'b0, 0);
      node_en[50] = 1'b0;
      vq = '{40, 60, 30};
      u_iaet_cpu_model.pulse(96'h1 << 20 | 96'h1 << 30 | 96'h1 << 40 | 96'h1 << 50 | 96'h1 << 60, 1'b0);
      repeat (3) serve(n, s);
      chk({node_flag[20], node_flag[50]}, 2'b11);
      repeat (3) begin
         trap_id = 3'($random(seed));
         jc_hit = 1'($random(seed));
         cfg(70, 15, 1'b0, 0);
         vq.push_back(128 + trap_id);
         vq.push_back(70);
         u_iaet_cpu_model.pulse(96'h1 << 70, 1'b1);
         serve(n, s);
         chk(n, jc_hit ? LAT_HIT + 2 : LAT_MISS + 2);
         chk(ns, jc_hit ? LAT_HIT : LAT_MISS);
         serve(n, s);
      end
      // shared nodes stay disabled, so their flags only accumulate
      sf = '0;
      for (int k = 0; k < 4; k++) begin
         source_select_regs[k*3 +: 3] = 3'($random(seed));
         shp((int'(source_select_regs[k*3 +: 3]) + 1) % 8);
         shp(int'(source_select_regs[k*3 +: 3]));
         chk(node_flag[88 + k], 1);
      end
      for (int j = 92; j < 96; j++) cfg(j, 15, 1'b0, 0);
      route = 16'h8421;
      gate_mode = 8'h55;
      for (int em = 1; em < 4; em++) begin
         edge_rise = {4{em[0]}};
         edge_fall = {4{em[1]}};
         edges(4'hF, {4{em[0]}});
         edges(4'h0, {4{em[1]}});
      end
      pat_sel = 16'h0002;
      edge_rise = 4'hF;
      edge_fall = 4'h0;
      for (int gm = 0; gm < 4; gm++) begin
         for (int p = 0; p < 2; p++) begin
            gate_mode = 8'(gm);
            edges(4'(p * 2), 4'h0);
            edges(4'(p * 2 + 1), {3'b000, gm == 1 || (gm == 2 && p == 1) || (gm == 3 && p == 0)});
            edges(4'h0, 4'h0);
         end
      end
      chk({bcnt, mcnt}, {nb, nm});
      conclude();
   end
endmodule : test_interrupt_and_event_transfer
